/* rtl/ppt_pkg.sv */
package ppt_pkg;

	// register byte addresses
	localparam logic [7:0] PPT_ADDR_CTRL    = 8'h00;
	localparam logic [7:0] PPT_ADDR_COUNT   = 8'h04;
	localparam logic [7:0] PPT_ADDR_STATUS  = 8'h08;
	localparam logic [7:0] PPT_ADDR_MASK    = 8'h0c;
	localparam logic [7:0] PPT_ADDR_POWER_CONTROL_REG    = 8'h10;
	localparam logic [7:0] PPT_ADDR_PORT0   = 8'h14;
	localparam logic [7:0] PPT_ADDR_PORT123 = 8'h18;

	// status and mask bit positions
	localparam int PPT_ST_EXT = 0;
	localparam int PPT_ST_OVF = 1;
	localparam int PPT_ST_W   = 2;

	// field positions
	localparam int PPT_CNT_LO_LSB = 0;
	localparam int PPT_CNT_HI_LSB = 8;

	// reset values
	localparam logic [15:0] PPT_COUNT_RST   = 16'h0000;
	localparam logic [7:0]  PPT_PORT0_RST   = 8'hff;
	localparam logic [23:0] PPT_PORT123_RST = 24'hffffff;
	localparam logic [1:0]  PPT_MASK_RST    = 2'h0;

	// oscillator clocks per machine cycle
	localparam logic [3:0] PPT_MC_DIV = 4'hc;

	// axi responses
	localparam logic [1:0] PPT_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PPT_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic global_interrupt_enable;
		logic edge_mode;
		logic gate;
		logic run;
	} ppt_ctrl_t;

	localparam ppt_ctrl_t PPT_CTRL_RST = '{default: 1'b0};

	typedef struct packed {
		logic power_down;
		logic idle;
	} ppt_power_control_reg_t;

	typedef enum logic [1:0] {
		PS_RUN,
		PS_IDLE,
		PS_DOWN
	} ppt_pstate_t;

endpackage

/* rtl/ppt_top.sv */
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
// Function
// - falling pin edge raises interrupt request
// - gated timer counts only while pin high
// - gate-stopping falling edge also raises interrupt
// - cleared run bit holds count, preload allowed
// - power-down stops fetching until reset
// - port zero floats in idle, power-down
// - ports one to three have pull-ups
// - port zero latch zeros drive pins low
// - port zero driven during bus only while BUS_DRIVE_I high
// - timer rollover interrupt wakes from idle
// - timer is two bytes wide
// - idle ends on reset or enabled interrupt
module ppt_top
	import ppt_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input  wire logic        CLK_I,
	input  wire logic        RESETN_I,
	input  wire logic [7:0]  AWADDR_I,
	input  wire logic        AWVALID_I,
	output logic             AWREADY_O,
	input  wire logic [31:0] WDATA_I,
	input  wire logic [3:0]  WSTRB_I,
	input  wire logic        WVALID_I,
	output logic             WREADY_O,
	output logic [1:0]       BRESP_O,
	output logic             BVALID_O,
	input  wire logic        BREADY_I,
	input  wire logic [7:0]  ARADDR_I,
	input  wire logic        ARVALID_I,
	output logic             ARREADY_O,
	output logic [31:0]      RDATA_O,
	output logic [1:0]       RRESP_O,
	output logic             RVALID_O,
	input  wire logic        RREADY_I,
	input  wire logic        EXT_INT_I,
	input  wire logic        BUS_ACTIVE_I,
	input  wire logic        BUS_DRIVE_I,
	input  wire logic [7:0]  BUS_DATA_I,
	output logic             IRQ_O,
	output logic             CPU_FETCH_EN_O,
	output logic             IDLE_O,
	output logic             IDLE_WAKE_O,
	output logic [7:0]       P0_O,
	output logic [7:0]       P0_OEN_O,
	output logic [23:0]      P123_O,
	output logic [23:0]      P123_OEN_O,
	output logic [23:0]      P123_PU_O
);

	// axi slave state
	logic        awready_q, wready_q, arready_q, bvalid_q, rvalid_q;
	logic        aw_have_q, w_have_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;

	// block state
	ppt_ctrl_t          ctrl_q;
	ppt_pstate_t        pstate_q, pstate_d;
	logic [CNT_W-1:0]   count_q, count_d;
	logic [PPT_ST_W-1:0] status_q, status_d, mask_q;
	logic [3:0]         div_q;
	logic               mc_tick_q;
	logic               pin_q, pin_prev_q;
	logic [7:0]         p0_latch_q;
	logic [23:0]        p123_latch_q;
	logic               irq_q, fetch_q, idle_q, wake_q;
	logic [7:0]         p0_q, p0_oen_q;

	// bus decode
	wire aw_take  = AWVALID_I & awready_q;
	wire w_take   = WVALID_I & wready_q;
	wire ar_take  = ARVALID_I & arready_q;
	wire do_write = aw_have_q & w_have_q & ~bvalid_q;
	wire bvalid_d = (bvalid_q & ~BREADY_I) | do_write;
	wire rvalid_d = (rvalid_q & ~RREADY_I) | ar_take;
	wire aw_have_d = (aw_have_q | aw_take) & ~do_write;
	wire w_have_d  = (w_have_q | w_take) & ~do_write;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		hit = (a[7:2] == reg_addr[7:2]);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = hit(a, PPT_ADDR_CTRL) | hit(a, PPT_ADDR_COUNT) | hit(a, PPT_ADDR_STATUS)
			| hit(a, PPT_ADDR_MASK) | hit(a, PPT_ADDR_POWER_CONTROL_REG) | hit(a, PPT_ADDR_PORT0)
			| hit(a, PPT_ADDR_PORT123);
	endfunction

	wire wr_ctrl   = do_write & hit(awaddr_q, PPT_ADDR_CTRL) & wstrb_q[0];
	wire wr_cnt_lo = do_write & hit(awaddr_q, PPT_ADDR_COUNT) & wstrb_q[0];
	wire wr_cnt_hi = do_write & hit(awaddr_q, PPT_ADDR_COUNT) & wstrb_q[1];
	wire wr_count  = wr_cnt_lo | wr_cnt_hi;
	wire wr_status = do_write & hit(awaddr_q, PPT_ADDR_STATUS) & wstrb_q[0];
	wire wr_mask   = do_write & hit(awaddr_q, PPT_ADDR_MASK) & wstrb_q[0];
	wire wr_power_control_reg   = do_write & hit(awaddr_q, PPT_ADDR_POWER_CONTROL_REG) & wstrb_q[0];
	wire wr_p0     = do_write & hit(awaddr_q, PPT_ADDR_PORT0) & wstrb_q[0];
	wire [3:0] wr_p123 = {4{do_write & hit(awaddr_q, PPT_ADDR_PORT123)}} & wstrb_q;
	wire ppt_power_control_reg_t power_control_reg_wr = wdata_q[1:0];

	// read mux
	wire [31:0] rd_mux =
		hit(ARADDR_I, PPT_ADDR_CTRL)    ? {28'h0, ctrl_q} :
		hit(ARADDR_I, PPT_ADDR_COUNT)   ? {16'h0, count_q} :
		hit(ARADDR_I, PPT_ADDR_STATUS)  ? {30'h0, status_q} :
		hit(ARADDR_I, PPT_ADDR_MASK)    ? {30'h0, mask_q} :
		hit(ARADDR_I, PPT_ADDR_POWER_CONTROL_REG)    ? {30'h0, pstate_q == PS_DOWN, pstate_q == PS_IDLE} :
		hit(ARADDR_I, PPT_ADDR_PORT0)   ? {24'h0, p0_latch_q} :
		hit(ARADDR_I, PPT_ADDR_PORT123) ? {8'h0, p123_latch_q} : 32'h0;

	// pin edge and timer enable; count frozen in power-down, divider keeps ticking
	wire fall     = pin_prev_q & ~pin_q;
	wire gate_ok  = ~ctrl_q.gate | pin_q;
	wire count_en = mc_tick_q & ctrl_q.run & gate_ok & (pstate_q != PS_DOWN);
	wire ovf      = count_en & (count_q == {CNT_W{1'b1}});
	wire ext_ev   = ctrl_q.edge_mode ? fall : ~pin_q;

	// count: software preload beats the increment
	always_comb begin
		count_d = count_q;
		if (count_en)
			count_d = count_q + 1'b1;
		if (wr_cnt_lo)
			count_d[PPT_CNT_LO_LSB +: 8] = wdata_q[7:0];
		if (wr_cnt_hi)
			count_d[PPT_CNT_HI_LSB +: 8] = wdata_q[15:8];
	end

	// sticky status: a set in the clearing cycle survives
	always_comb begin
		status_d = status_q;
		if (wr_status)
			status_d = status_q & ~wdata_q[PPT_ST_W-1:0];
		if (ext_ev)
			status_d[PPT_ST_EXT] = 1'b1;
		if (ovf)
			status_d[PPT_ST_OVF] = 1'b1;
	end

	wire pend = |(status_q & mask_q) & ctrl_q.global_interrupt_enable;

	// power state: power-down leaves only through reset
	always_comb begin
		pstate_d = pstate_q;
		case (pstate_q)
			PS_RUN: begin
				if (wr_power_control_reg & power_control_reg_wr.power_down)
					pstate_d = PS_DOWN;
				else if (wr_power_control_reg & power_control_reg_wr.idle)
					pstate_d = PS_IDLE;
			end
			PS_IDLE: begin
				if (pend)
					pstate_d = PS_RUN;
				else if (wr_power_control_reg & power_control_reg_wr.power_down)
					pstate_d = PS_DOWN;
			end
			PS_DOWN: pstate_d = PS_DOWN;
			default: pstate_d = PS_RUN;
		endcase
	end

	// port zero: low-power float first, then bus, then latch
	wire        low_pwr  = (pstate_q != PS_RUN);
	wire [7:0]  p0_oen_d = low_pwr ? 8'hff :
		BUS_ACTIVE_I ? (BUS_DRIVE_I ? 8'h00 : 8'hff) :
		p0_latch_q;
	wire [7:0]  p0_d = (BUS_ACTIVE_I & ~low_pwr) ? BUS_DATA_I : 8'h00;

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			arready_q <= 1'b0;
			bvalid_q  <= 1'b0;
			rvalid_q  <= 1'b0;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
			bresp_q   <= PPT_RESP_OKAY;
			rresp_q   <= PPT_RESP_OKAY;
			rdata_q   <= 32'h0;
		end else begin
			awready_q <= ~aw_have_d & ~bvalid_d;
			wready_q  <= ~w_have_d & ~bvalid_d;
			arready_q <= ~rvalid_d;
			bvalid_q  <= bvalid_d;
			rvalid_q  <= rvalid_d;
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			if (aw_take)
				awaddr_q <= AWADDR_I;
			if (w_take) begin
				wdata_q <= WDATA_I;
				wstrb_q <= WSTRB_I;
			end
			if (do_write)
				bresp_q <= mapped(awaddr_q) ? PPT_RESP_OKAY : PPT_RESP_SLVERR;
			if (ar_take) begin
				rdata_q <= rd_mux;
				rresp_q <= mapped(ARADDR_I) ? PPT_RESP_OKAY : PPT_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			div_q     <= 4'h0;
			mc_tick_q <= 1'b0;
		end else begin
			// one tick per machine cycle
			div_q     <= (div_q == PPT_MC_DIV - 4'h1) ? 4'h0 : div_q + 4'h1;
			mc_tick_q <= (div_q == PPT_MC_DIV - 4'h1);
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			pin_q        <= 1'b1;
			pin_prev_q   <= 1'b1;
			ctrl_q       <= PPT_CTRL_RST;
			count_q      <= PPT_COUNT_RST;
			status_q     <= '0;
			mask_q       <= PPT_MASK_RST;
			pstate_q     <= PS_RUN;
			p0_latch_q   <= PPT_PORT0_RST;
			p123_latch_q <= PPT_PORT123_RST;
		end else begin
			pin_q      <= EXT_INT_I;
			pin_prev_q <= pin_q;
			if (wr_ctrl)
				ctrl_q <= wdata_q[3:0];
			count_q  <= count_d;
			status_q <= status_d;
			if (wr_mask)
				mask_q <= wdata_q[PPT_ST_W-1:0];
			pstate_q <= pstate_d;
			if (wr_p0)
				p0_latch_q <= wdata_q[7:0];
			for (int i = 0; i < 3; i++) begin
				if (wr_p123[i])
					p123_latch_q[i*8 +: 8] <= wdata_q[i*8 +: 8];
			end
		end
	end

	// outputs, all registered
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			irq_q    <= 1'b0;
			fetch_q  <= 1'b1;
			idle_q   <= 1'b0;
			wake_q   <= 1'b0;
			p0_q     <= 8'h00;
			p0_oen_q <= 8'hff;
		end else begin
			irq_q    <= |(status_d & mask_q) & ctrl_q.global_interrupt_enable;
			fetch_q  <= (pstate_d == PS_RUN);
			idle_q   <= (pstate_d == PS_IDLE);
			wake_q   <= (pstate_q == PS_IDLE) & (pstate_d == PS_RUN);
			p0_q     <= p0_d;
			p0_oen_q <= p0_oen_d;
		end
	end

	assign AWREADY_O      = awready_q;
	assign WREADY_O       = wready_q;
	assign BVALID_O       = bvalid_q;
	assign BRESP_O        = bresp_q;
	assign ARREADY_O      = arready_q;
	assign RVALID_O       = rvalid_q;
	assign RDATA_O        = rdata_q;
	assign RRESP_O        = rresp_q;
	assign IRQ_O          = irq_q;
	assign CPU_FETCH_EN_O = fetch_q;
	assign IDLE_O         = idle_q;
	assign IDLE_WAKE_O    = wake_q;
	assign P0_O           = p0_q;
	assign P0_OEN_O       = p0_oen_q;
	// low latch bits sink, high bits rest on the pull-ups
	assign P123_O         = 24'h0;
	assign P123_OEN_O     = p123_latch_q;
	assign P123_PU_O      = PPT_PORT123_RST;

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESETN_I);

	a_edge_sets_flag: assert property (
		(ctrl_q.edge_mode & fall) |=> status_q[PPT_ST_EXT])
		else $error("falling edge did not set the pin flag");

	a_gate_holds_low: assert property (
		(ctrl_q.gate & ~pin_q & ~wr_count) |=> (count_q == $past(count_q)))
		else $error("gated timer moved while pin low");

	a_gate_stop_irq: assert property (
		(ctrl_q.gate & ctrl_q.edge_mode & fall & mask_q[PPT_ST_EXT]
			& ctrl_q.global_interrupt_enable & ~do_write) ##1 ~do_write |=> IRQ_O)
		else $error("gate-stopping edge gave no interrupt");

	a_stopped_holds: assert property (
		(~ctrl_q.run & ~wr_count) |=> $stable(count_q))
		else $error("stopped timer changed");

	a_pd_sticky: assert property (
		(pstate_q == PS_DOWN) |=> (pstate_q == PS_DOWN) && !CPU_FETCH_EN_O)
		else $error("left power-down or fetched without reset");

	a_p0_floats: assert property (
		(pstate_q != PS_RUN) |=> (P0_OEN_O == 8'hff))
		else $error("port zero driven in low power");

	a_p0_latch_drive: assert property (
		(pstate_q == PS_RUN & ~BUS_ACTIVE_I) |=> (P0_OEN_O == $past(p0_latch_q)) && (P0_O == 8'h00))
		else $error("port zero not following latch zeros");

	a_bus_driven: assert property (
		(pstate_q == PS_RUN & BUS_ACTIVE_I & BUS_DRIVE_I) |=> (P0_OEN_O == 8'h00))
		else $error("port zero not driven during bus cycle");

	a_wrap_flag: assert property (
		(ovf & ~wr_count) |=> (count_q == '0) && status_q[PPT_ST_OVF])
		else $error("overflow did not wrap and flag");

	a_tick_spacing: assert property (
		mc_tick_q |=> !mc_tick_q [*8])
		else $error("machine cycle tick too frequent");

	a_idle_wake: assert property (
		(pstate_q == PS_IDLE & pend) |=> (pstate_q == PS_RUN) && IDLE_WAKE_O)
		else $error("enabled interrupt did not end idle");

endmodule

/* sim/ppt_xdcr_model.sv */
`timescale 1ns/100ps
module ppt_xdcr_model #(
	parameter int HALF = 120
) (
	input  wire logic clk_i,
	input  wire logic en_i,
	output logic      pin_o
);
	int   cnt_q = 0;
	logic pin_q = 1'b1;
	assign pin_o = pin_q;
	// idles high so level mode sees no event; enabling starts with a fall
	always @(posedge clk_i) begin
		if (!en_i) begin
			cnt_q <= 0;
			pin_q <= 1'b1;
		end else begin
			cnt_q <= (cnt_q == 2 * HALF - 1) ? 0 : cnt_q + 1;
			pin_q <= (cnt_q >= HALF - 1) && (cnt_q != 2 * HALF - 1);
		end
	end
endmodule

/* sim/test_ppt_top.sv */
`timescale 1ns/100ps
module test_ppt_top import ppt_pkg::*;;
	logic        CLK_I = 1'b0, RESETN_I = 1'b0, AWVALID_I = 1'b0, WVALID_I = 1'b0;
	logic        BREADY_I = 1'b0, ARVALID_I = 1'b0, RREADY_I = 1'b0, x_en = 1'b0;
	logic        BUS_ACTIVE_I = 1'b0, BUS_DRIVE_I = 1'b0, w_seen;
	logic [7:0]  AWADDR_I = 8'h00, ARADDR_I = 8'h00, BUS_DATA_I = 8'h00, P0_O, P0_OEN_O;
	logic [31:0] WDATA_I = 32'h0, RDATA_O, rd;
	logic [3:0]  WSTRB_I = 4'hf;
	logic [1:0]  BRESP_O, RRESP_O, rsp;
	logic        AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, IRQ_O;
	logic        CPU_FETCH_EN_O, IDLE_O, IDLE_WAKE_O;
	logic [23:0] P123_O, P123_OEN_O, P123_PU_O;
	wire logic   EXT_INT_I;
	int          failures = 0, total_checks = 0, i;
	logic [7:0]  ra [7] = '{PPT_ADDR_CTRL, PPT_ADDR_COUNT, PPT_ADDR_STATUS, PPT_ADDR_MASK,
		PPT_ADDR_POWER_CONTROL_REG, PPT_ADDR_PORT0, PPT_ADDR_PORT123};
	logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hff, 32'hffffff};

	ppt_top ppt_top_i (
		.CLK_I          (CLK_I),
		.RESETN_I       (RESETN_I),
		.AWADDR_I       (AWADDR_I),
		.AWVALID_I      (AWVALID_I),
		.AWREADY_O      (AWREADY_O),
		.WDATA_I        (WDATA_I),
		.WSTRB_I        (WSTRB_I),
		.WVALID_I       (WVALID_I),
		.WREADY_O       (WREADY_O),
		.BRESP_O        (BRESP_O),
		.BVALID_O       (BVALID_O),
		.BREADY_I       (BREADY_I),
		.ARADDR_I       (ARADDR_I),
		.ARVALID_I      (ARVALID_I),
		.ARREADY_O      (ARREADY_O),
		.RDATA_O        (RDATA_O),
		.RRESP_O        (RRESP_O),
		.RVALID_O       (RVALID_O),
		.RREADY_I       (RREADY_I),
		.EXT_INT_I      (EXT_INT_I),
		.BUS_ACTIVE_I   (BUS_ACTIVE_I),
		.BUS_DRIVE_I    (BUS_DRIVE_I),
		.BUS_DATA_I     (BUS_DATA_I),
		.IRQ_O          (IRQ_O),
		.CPU_FETCH_EN_O (CPU_FETCH_EN_O),
		.IDLE_O         (IDLE_O),
		.IDLE_WAKE_O    (IDLE_WAKE_O),
		.P0_O           (P0_O),
		.P0_OEN_O       (P0_OEN_O),
		.P123_O         (P123_O),
		.P123_OEN_O     (P123_OEN_O),
		.P123_PU_O      (P123_PU_O)
	);
	ppt_xdcr_model #(.HALF(120)) ppt_xdcr_model_i (.clk_i(CLK_I), .en_i(x_en), .pin_o(EXT_INT_I));

	always #2.5 CLK_I = ~CLK_I;

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// leading edge keeps two tasks from driving a strobe in one step
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_I);
		AWADDR_I <= a;
		WDATA_I <= d;
		AWVALID_I <= 1'b1;
		WVALID_I <= 1'b1;
		BREADY_I <= 1'b1;
		do begin
			@(posedge CLK_I);
			AWVALID_I <= AWVALID_I & ~AWREADY_O;
			WVALID_I <= WVALID_I & ~WREADY_O;
		end while (!(BVALID_O === 1'b1 && BREADY_I));
		rsp = BRESP_O;
		BREADY_I <= 1'b0;
		repeat (2) @(posedge CLK_I);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
		@(posedge CLK_I);
		ARADDR_I <= a;
		ARVALID_I <= 1'b1;
		RREADY_I <= 1'b1;
		do begin
			@(posedge CLK_I);
			ARVALID_I <= ARVALID_I & ~ARREADY_O;
		end while (!(RVALID_O === 1'b1 && RREADY_I));
		rd = RDATA_O;
		rsp = RRESP_O;
		RREADY_I <= 1'b0;
		chk(nm, rd, exp);
	endtask

	task automatic stop_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge CLK_I);
		failures++;
		stop_test();
	end

	initial begin
		repeat (20) @(posedge CLK_I);
		RESETN_I <= 1'b1;
		repeat (3) @(posedge CLK_I);
		chk("pull-ups", P123_PU_O, 24'hffffff);
		for (i = 0; i < 7; i++) begin
			rc(ra[i], rv[i], "reset value");
		end
		rc(8'h1c, 32'h0, "unmapped read");
		chk("unmapped rresp", rsp, PPT_RESP_SLVERR);
		axw(8'h1c, 32'hffffffff);
		chk("unmapped bresp", rsp, PPT_RESP_SLVERR);
		axw(PPT_ADDR_COUNT, 32'h1234);
		chk("write bresp", rsp, PPT_RESP_OKAY);
		repeat (40) @(posedge CLK_I);
		rc(PPT_ADDR_COUNT, 32'h1234, "stopped count");
		// only the low byte lane may land
		WSTRB_I <= 4'h1;
		axw(PPT_ADDR_COUNT, 32'hffff);
		WSTRB_I <= 4'hf;
		rc(PPT_ADDR_COUNT, 32'h12ff, "low byte preload");
		axw(PPT_ADDR_COUNT, 32'hfffe);
		axw(PPT_ADDR_CTRL, 32'h1);
		repeat (30) @(posedge CLK_I);
		axw(PPT_ADDR_CTRL, 32'h0);
		rc(PPT_ADDR_STATUS, 32'h2, "overflow flag");
		// 36 running edges give exactly three machine cycles
		rc(PPT_ADDR_COUNT, 32'h1, "wrapped count");
		chk("wrapped count", 32'(rd < 32'h3), 32'h1);
		axw(PPT_ADDR_STATUS, 32'h3);
		rc(PPT_ADDR_STATUS, 32'h0, "status cleared");
		// edge event, interrupt path, then the gated timer on the same pulse
		axw(PPT_ADDR_MASK, 32'h1);
		axw(PPT_ADDR_CTRL, 32'hc);
		x_en <= 1'b1;
		repeat (6) @(posedge CLK_I);
		chk("irq on fall", IRQ_O, 1'b1);
		axw(PPT_ADDR_CTRL, 32'hf);
		axw(PPT_ADDR_COUNT, 32'h0);
		rc(PPT_ADDR_STATUS, 32'h1, "fall event");
		axw(PPT_ADDR_STATUS, 32'h1);
		chk("irq cleared", IRQ_O, 1'b0);
		rc(PPT_ADDR_COUNT, 32'h0, "gate low");
		repeat (250) @(posedge CLK_I);
		rc(PPT_ADDR_STATUS, 32'h1, "gate stop event");
		chk("gate irq", IRQ_O, 1'b1);
		// a 120-clock high phase is ten machine cycles
		rc(PPT_ADDR_COUNT, 32'ha, "gated count exact");
		chk("gated count", 32'(rd >= 32'h9 && rd <= 32'hb), 32'h1);
		rc(PPT_ADDR_COUNT, rd, "gate held");
		axw(PPT_ADDR_CTRL, 32'hc);
		x_en <= 1'b0;
		axw(PPT_ADDR_PORT0, 32'h0);
		chk("p0 sink", P0_OEN_O, 8'h00);
		axw(PPT_ADDR_PORT123, 32'h00ff00);
		chk("p123 latch", P123_OEN_O, 24'h00ff00);
		chk("p123 sink value", P123_O, 24'h0);
		BUS_ACTIVE_I <= 1'b1;
		BUS_DRIVE_I <= 1'b1;
		BUS_DATA_I <= 8'ha5;
		repeat (3) @(posedge CLK_I);
		chk("bus data", {P0_OEN_O, P0_O}, 16'h00a5);
		BUS_DRIVE_I <= 1'b0;
		repeat (3) @(posedge CLK_I);
		chk("memory drives", P0_OEN_O, 8'hff);
		BUS_ACTIVE_I <= 1'b0;
		// idle left by overflow; far from rollover so entry is seen first
		axw(PPT_ADDR_STATUS, 32'h3);
		axw(PPT_ADDR_MASK, 32'h2);
		axw(PPT_ADDR_COUNT, 32'hfff0);
		axw(PPT_ADDR_CTRL, 32'h9);
		axw(PPT_ADDR_POWER_CONTROL_REG, 32'h1);
		chk("idle entry", {IDLE_O, CPU_FETCH_EN_O}, 2'h2);
		chk("idle float", P0_OEN_O, 8'hff);
		w_seen = 1'b0;
		for (i = 0; i < 400 && !w_seen; i++) begin
			@(posedge CLK_I);
			w_seen = (IDLE_WAKE_O === 1'b1);
		end
		repeat (2) @(posedge CLK_I);
		chk("wake pulse", w_seen, 1'b1);
		chk("idle exit", {IDLE_O, CPU_FETCH_EN_O}, 2'h1);
		axw(PPT_ADDR_CTRL, 32'h0);
		axw(PPT_ADDR_POWER_CONTROL_REG, 32'h2);
		repeat (50) @(posedge CLK_I);
		chk("pd fetch", CPU_FETCH_EN_O, 1'b0);
		chk("pd float", P0_OEN_O, 8'hff);
		rc(PPT_ADDR_POWER_CONTROL_REG, 32'h2, "pd state");
		RESETN_I <= 1'b0;
		repeat (20) @(posedge CLK_I);
		RESETN_I <= 1'b1;
		repeat (3) @(posedge CLK_I);
		chk("fetch after reset", CPU_FETCH_EN_O, 1'b1);
		stop_test();
	end
endmodule
